/* File: src/cdc_map.vh */
// Constants of the comparator digital control block.
`ifndef CDC_MAP_VH
`define CDC_MAP_VH
`define CDC_NUM_CMP      2
`define CDC_CH_W         3
`define CDC_RST_LOW      1'h0
`define CDC_RST_HIGH     1'h1
`define CDC_SYNC_STAGES  3
`endif

/* File: src/cdc_unit.v */
// One comparator channel: enable, polarity, latches, edge flags.
`include "cdc_map.vh"
module cdc_unit (
    input  wire clk,
    input  wire rst_n,
    input  wire cmp_enable,
    input  wire cmp_invert,
    input  wire cmp_timer_sync_en,
    input  wire raw_stable,
    input  wire t1_fall,
    input  wire int_pos_en,
    input  wire int_neg_en,
    input  wire flag_clear,
    output reg  cmp_result_bit,
    output reg  timer_gate_src,
    output reg  int_flag
);
    wire polar;
    reg  sync_latch;
    reg  next_result;

    ////////////////////////////////////////////////////////////////////
    // Disabled comparator reads low whatever the inputs do.
    assign polar = cmp_enable & (raw_stable ^ cmp_invert);

    always @* begin
        next_result = polar;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_result_bit <= `CDC_RST_LOW;
            sync_latch     <= `CDC_RST_LOW;
            timer_gate_src <= `CDC_RST_LOW;
            int_flag       <= `CDC_RST_LOW;
        end else begin
            cmp_result_bit <= next_result;
            if (t1_fall)
                sync_latch <= polar;
            timer_gate_src <= cmp_timer_sync_en ? sync_latch : polar;
            // Set wins over a clear in the same cycle.
            if ((int_pos_en & next_result & ~cmp_result_bit) |
                (int_neg_en & ~next_result & cmp_result_bit))
                int_flag <= `CDC_RST_HIGH;
            else if (flag_clear)
                int_flag <= `CDC_RST_LOW;
        end
    end
endmodule

/* File: src/cdc_top.v */
// Top level of the two-comparator digital control block.
//
// Notes on behaviour
// - Non-inverting input below inverting input gives a low raw result.
// - Non-inverting input above inverting input gives a high raw result.
// - A comparator works only while enabled; cleared enable means lowest power.
// - Result readable from own bit and from shared mirror bits.
// - Result can be routed to a pin through output selection.
// - Internal result is latched every cycle; pin path stays unlatched.
// - Invert bit set inverts the result; cleared passes it straight.
// - Hysteresis select is driven to the analog section.
// - Result is offered as a gate source for the 16-bit timer.
// - Sync bit routes the result through a timer-clocked latch.
// - With sync, result is captured on the falling timer source edge.
// - Separate rising and falling edge interrupt enables per comparator.
// - Independent positive and negative input channel selects per comparator.
// - Two comparator instances, each with its own control settings.
`include "cdc_map.vh"
module cdc_top #(
    parameter N   = `CDC_NUM_CMP,
    parameter CHW = `CDC_CH_W
) (
    input  wire           clk,
    input  wire           resetn,
    input  wire [N-1:0]   cmp_raw_in,
    input  wire           t1_src_clk,
    input  wire [N-1:0]   cmp_enable,
    input  wire [N-1:0]   cmp_invert,
    input  wire [N-1:0]   cmp_hysteresis_en,
    input  wire [N-1:0]   cmp_timer_sync_en,
    input  wire [N-1:0]   int_pos_en,
    input  wire [N-1:0]   int_neg_en,
    input  wire [N-1:0]   int_flag_clear,
    input  wire [N*CHW-1:0] cmp_pos_input,
    input  wire [N*CHW-1:0] cmp_neg_input,
    input  wire [N-1:0]   pin_output_select,
    output wire [N-1:0]   cmp_result_bit,
    output wire [N-1:0]   cmp_result_mirror_reg,
    output wire [N-1:0]   timer_gate_src,
    output wire [N-1:0]   int_flag,
    output wire           cmp_pin_out,
    output wire [N-1:0]   analog_enable,
    output wire [N-1:0]   analog_hysteresis,
    output wire [N*CHW-1:0] analog_pos_sel,
    output wire [N*CHW-1:0] analog_neg_sel
);
    reg  [1:0]     rst_sync;
    wire           rst_n;

    reg  [N-1:0]   raw_s0;
    reg  [N-1:0]   raw_s1;
    reg  [N-1:0]   raw_s2;
    reg  [N-1:0]   raw_stable;
    reg  [N-1:0]   next_raw_stable;
    integer        k;

    reg  [2:0]     t1_s;
    reg            t1_stable;
    reg            next_t1_stable;
    reg            t1_fall;

    wire [N-1:0]   pin_path;
    reg            pin_mux;
    integer        m;
    genvar         g;

    ////////////////////////////////////////////////////////////////////
    // A sampled level moves only once the second and third stages agree,
    // so a metastable first stage never reaches the logic behind it.
    function agreed_level;
        input held;
        input stage2;
        input stage3;
        begin
            if (stage2 == stage3) begin
                agreed_level = stage3;
            end else begin
                agreed_level = held;
            end
        end
    endfunction

    // Enable and polarity applied to a filtered raw result; a disabled
    // comparator always reads low.
    function shaped_result;
        input enable;
        input raw;
        input invert;
        begin
            shaped_result = enable & (raw ^ invert);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Reset release through two flops. Assertion stays asynchronous, so
    // the block clears even while no clock is running.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= {2{`CDC_RST_LOW}};
        end else begin
            rst_sync <= {rst_sync[0], `CDC_RST_HIGH};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////
    // The raw comparator results arrive from the analog side with no
    // relation to the clock, so they pass three flops first.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_s0 <= {N{`CDC_RST_LOW}};
        end else begin
            raw_s0 <= cmp_raw_in;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_s1 <= {N{`CDC_RST_LOW}};
        end else begin
            raw_s1 <= raw_s0;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_s2 <= {N{`CDC_RST_LOW}};
        end else begin
            raw_s2 <= raw_s1;
        end
    end

    // The filtered level holds while stages two and three disagree.
    always @* begin
        next_raw_stable = {N{`CDC_RST_LOW}};
        for (k = 0; k < N; k = k + 1) begin
            next_raw_stable[k] = agreed_level(raw_stable[k],
                                              raw_s1[k],
                                              raw_s2[k]);
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_stable <= {N{`CDC_RST_LOW}};
        end else begin
            raw_stable <= next_raw_stable;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // The timer source clock is filtered like any pin. Its agreed level
    // resets low, so reset can never look like a falling edge; the cost
    // is a lag of about three cycles behind the real edge.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t1_s <= {3{`CDC_RST_LOW}};
        end else begin
            t1_s <= {t1_s[1:0], t1_src_clk};
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t1_stable <= `CDC_RST_LOW;
        end else begin
            t1_stable <= next_t1_stable;
        end
    end

    always @* begin
        next_t1_stable = agreed_level(t1_stable, t1_s[1], t1_s[2]);
        t1_fall        = t1_stable & ~next_t1_stable;
    end

    ////////////////////////////////////////////////////////////////////
    generate
        for (g = 0; g < N; g = g + 1) begin : unit
            cdc_unit u_cmp (
                .clk               (clk),
                .rst_n             (rst_n),
                .cmp_enable        (cmp_enable[g]),
                .cmp_invert        (cmp_invert[g]),
                .cmp_timer_sync_en (cmp_timer_sync_en[g]),
                .raw_stable        (raw_stable[g]),
                .t1_fall           (t1_fall),
                .int_pos_en        (int_pos_en[g]),
                .int_neg_en        (int_neg_en[g]),
                .flag_clear        (int_flag_clear[g]),
                .cmp_result_bit    (cmp_result_bit[g]),
                .timer_gate_src    (timer_gate_src[g]),
                .int_flag          (int_flag[g])
            );
            // The pin path skips the status latch, so it leads that bit
            // by one cycle.
            assign pin_path[g] = shaped_result(cmp_enable[g],
                                               raw_stable[g],
                                               cmp_invert[g]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Every selected comparator is ORed onto the one pin; selecting two
    // merges them, so software should select a single one.
    always @* begin
        pin_mux = `CDC_RST_LOW;
        for (m = 0; m < N; m = m + 1) begin
            pin_mux = pin_mux | (pin_output_select[m] & pin_path[m]);
        end
    end
    assign cmp_pin_out = pin_mux;

    ////////////////////////////////////////////////////////////////////
    // The mirror bits are the status flops themselves, so the two reads
    // can never disagree.
    assign cmp_result_mirror_reg = cmp_result_bit;
    assign analog_enable         = cmp_enable;
    // A disabled comparator also drops its hysteresis request.
    assign analog_hysteresis     = cmp_hysteresis_en & cmp_enable;
    // Channel selects pass straight to the analog multiplexers.
    assign analog_pos_sel        = cmp_pos_input;
    assign analog_neg_sel        = cmp_neg_input;
endmodule

/* File: tb/cdc_asserts.sv */
// Concurrent checks on the comparator control ports.
module cdc_asserts #(parameter N = 2, parameter CHW = 3) (
    input logic         clk, resetn, cmp_pin_out,
    input logic [N-1:0] cmp_enable, cmp_hysteresis_en, cmp_timer_sync_en,
    input logic [N-1:0] int_pos_en, int_neg_en, int_flag_clear,
    input logic [N-1:0] pin_output_select,
    input logic [N-1:0] cmp_result_bit, cmp_result_mirror_reg, int_flag,
    input logic [N-1:0] timer_gate_src, analog_enable, analog_hysteresis
);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_off; !cmp_enable[0] [*2]; endsequence
    sequence s_pin; (pin_output_select == 2'h1 && cmp_enable[0]) [*2];
    endsequence
    chk_mirror_same: assert property (
        cmp_result_mirror_reg == cmp_result_bit) else $error("mirror");
    chk_analog_on: assert property (
        analog_enable == cmp_enable) else $error("analog enable");
    chk_hyst_drive: assert property (
        analog_hysteresis == (cmp_hysteresis_en & cmp_enable))
        else $error("hysteresis");
    chk_off_low: assert property (s_off |-> !cmp_result_bit[0])
        else $error("disabled result");
    chk_pin_leads: assert property (
        s_pin |-> cmp_result_bit[0] == $past(cmp_pin_out)) else $error("pin");
    chk_flag_rise: assert property (
        $rose(cmp_result_bit[0]) && $past(int_pos_en[0]) |-> int_flag[0])
        else $error("flag set");
    chk_flag_fall: assert property (
        $fell(cmp_result_bit[0]) && $past(int_neg_en[0]) |-> int_flag[0])
        else $error("flag fall");
    chk_flag_hold: assert property (
        int_flag[0] && !int_flag_clear[0] |=> int_flag[0])
        else $error("flag hold");
    chk_gate_direct: assert property (
        !cmp_timer_sync_en[0] [*2] |-> timer_gate_src[0] == cmp_result_bit[0])
        else $error("gate");
endmodule
bind cdc_top cdc_asserts #(.N(N), .CHW(CHW)) u_chk (.*);

/* File: tb/cdc_far.sv */
// Far side: two analog input pairs and a free timer source clock.
module cdc_far (
    input  logic        clk,
    input  logic [15:0] vp, vn,
    output logic [1:0]  cmp_raw_in,
    output logic        t1_src_clk = 1'h0
);
    timeunit 1ns; timeprecision 1ns;
    logic [1:0] div = 2'h0;
    assign cmp_raw_in = {vp[15:8] > vn[15:8], vp[7:0] > vn[7:0]};
    always @(posedge clk) begin
        div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        if (div == 2'h2) t1_src_clk <= ~t1_src_clk;
    end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the comparator control block.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    timeunit 1ns; timeprecision 1ns;
    logic clk = 0, resetn = 0, t1_src_clk, cmp_pin_out;
    logic [1:0] cmp_enable = 3, cmp_invert = 0, cmp_hysteresis_en = 0;
    logic [1:0] cmp_timer_sync_en = 0, int_pos_en = 0, int_neg_en = 0;
    logic [1:0] int_flag_clear = 0, pin_output_select = 0, cmp_raw_in;
    logic [1:0] cmp_result_bit, cmp_result_mirror_reg, timer_gate_src;
    logic [1:0] int_flag, analog_enable, analog_hysteresis, ex, ef, pv;
    logic [5:0] cmp_pos_input = 0, cmp_neg_input = 0;
    logic [5:0] analog_pos_sel, analog_neg_sel;
    // Odd low bits keep each level off 8'h80, where the result is undefined.
    logic [15:0] vp = 16'h0101, vn = 16'h8080;
    integer err_total = 0, compares = 0, i, ph;
    always #10 clk = ~clk;
    cdc_far u_far (.*);
    cdc_top u_dut (.*);
    task step(input integer n); repeat (n) @(posedge clk); endtask
    function automatic logic [1:0] model(input logic [1:0] en, inv);
        model = 2'h0;
        for (int k = 0; k < 2; k++)
            model[k] = en[k] & ((vp[8*k+:8] > vn[8*k+:8]) ^ inv[k]);
    endfunction
    task wrap_up;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        void'($urandom(28));
        step(12); resetn <= 1; step(3);
        for (ph = 0; ph < 4; ph++) begin
            cmp_invert <= ph;
            cmp_enable <= (ph == 3) ? 2'h2 : 2'h3;
            cmp_timer_sync_en <= (ph == 2) ? 2'h3 : 2'h0;
            step(10); int_flag_clear <= 3; step(1); int_flag_clear <= 0;
            step(1); pv = model(cmp_enable, cmp_invert);
            for (i = 0; i < 6; i++) begin
                vp <= $urandom | 16'h0101;
                {int_pos_en, int_neg_en, pin_output_select} <= $urandom;
                {cmp_hysteresis_en, cmp_pos_input, cmp_neg_input} <= $urandom;
                step(1);
                ex = model(cmp_enable, cmp_invert);
                ef = (ex & ~pv & int_pos_en) | (~ex & pv & int_neg_en);
                step(10);
                @(negedge clk);
                `CHK(cmp_result_bit, ex)
                `CHK(cmp_result_mirror_reg, ex)
                `CHK(timer_gate_src, ex)
                `CHK(cmp_pin_out, |(ex & pin_output_select))
                `CHK(int_flag, ef)
                `CHK(analog_hysteresis, cmp_hysteresis_en & cmp_enable)
                `CHK(analog_pos_sel, cmp_pos_input)
                `CHK(analog_neg_sel, cmp_neg_input)
                step(1); int_flag_clear <= 3;
                step(1); int_flag_clear <= 0; pv = ex;
            end
            $display("phase %0d done", ph);
        end
        wrap_up;
    end
endmodule
